// file: core/fcl_pkg.sv
// Functional notes
// [RQ1] software sets divider for 1 MHz base
// [RQ2] no program or erase below 1 MHz
// [RQ3] divider write sets loaded bit, zero after reset
// [RQ4] no divider load: refuse program/erase, access error
// [RQ5] software clears error flags, checks completion first
// [RQ6] command busy: ignore parameter writes and launches
// [RQ7] software avoids register writes while busy
// [RQ8] parameter word chosen by 3-bit index
// [RQ9] write one clears completion flag, launches
// [RQ10] completion flag sets when command finishes
// [RQ11] decode verify codes 0x01, 0x02, 0x03
// [RQ12] 0x07 program-once field, 0x04 reads it
// [RQ13] 0x06 programs one program-memory phrase
// [RQ14] 0x08 needs all four open bits
// [RQ15] 0x09 full block needs three open bits
// [RQ16] 0x0a erases one program-memory sector
// [RQ17] 0x0b erase unsecure, 0x0c key check
// [RQ18] 0x0d user margin, 0x0e field margin
// [RQ19] data-memory codes 0x10, 0x11, 0x12
// [RQ20] 0x08, 0x0b special modes; 0x0e unsecured special
// [RQ21] secured non-single-chip: only verify and special
// [RQ22] 0x0c only in normal single-chip mode
// [RQ23] command code in high byte of word 0
// [RQ24] unsupported code sets access error
// [RQ25] refused launch: access error, completion back
package fcl_pkg;
  // =====================================================
  // command codes
  localparam logic [7:0] CMD_VFY_ALL   = 8'h01;
  localparam logic [7:0] CMD_VFY_BLK   = 8'h02;
  localparam logic [7:0] CMD_VFY_SECT  = 8'h03;
  localparam logic [7:0] CMD_RD_ONCE   = 8'h04;
  localparam logic [7:0] CMD_PGM_PH    = 8'h06;
  localparam logic [7:0] CMD_PGM_ONCE  = 8'h07;
  localparam logic [7:0] CMD_ERS_ALL   = 8'h08;
  localparam logic [7:0] CMD_ERS_BLK   = 8'h09;
  localparam logic [7:0] CMD_ERS_SECT  = 8'h0a;
  localparam logic [7:0] CMD_UNSEC     = 8'h0b;
  localparam logic [7:0] CMD_KEY_VFY   = 8'h0c;
  localparam logic [7:0] CMD_USR_MRG   = 8'h0d;
  localparam logic [7:0] CMD_FLD_MRG   = 8'h0e;
  localparam logic [7:0] CMD_D_VFY     = 8'h10;
  localparam logic [7:0] CMD_D_PGM     = 8'h11;
  localparam logic [7:0] CMD_D_ERS     = 8'h12;
  // =====================================================
  // chip modes on the mode input
  localparam logic [1:0] MODE_NS       = 2'h0;  // normal single-chip
  localparam logic [1:0] MODE_NX       = 2'h1;  // normal expanded
  localparam logic [1:0] MODE_SS       = 2'h2;  // special single-chip
  localparam logic [1:0] MODE_ST       = 2'h3;  // special
  // =====================================================
  // array layout and reset values
  localparam int         PARAM_WORDS   = 6;     // implemented words
  localparam int         CMD_HI_BIT    = 15;    // code in high byte
  localparam logic [5:0] DIV_RESET     = 6'h00;
  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam logic [2:0] IDX_RESET     = 3'h0;
  // =====================================================
  // timing
  localparam int         CLK_MHZ       = 100;
  localparam int         LAUNCH_NS     = 10;    // launch handshake
  localparam int         LAUNCH_CYC    = (LAUNCH_NS * CLK_MHZ + 999) / 1000;
  // sequencer states
  typedef enum logic [1:0] {
    FCL_IDLE = 2'b00,
    FCL_BUSY = 2'b01,
    FCL_DONE = 2'b11
  } fcl_state_t;
endpackage

// file: core/fcl_top.sv
`timescale 1ns/100ps
module fcl_top import fcl_pkg::*; #(
  parameter int DIV_W = 6
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // divider register write
  input  wire logic             div_wr_i,
  input  wire logic [DIV_W-1:0] div_wdata_i,
  // parameter index and array access
  input  wire logic             idx_wr_i,
  input  wire logic [2:0]       idx_wdata_i,
  input  wire logic             param_wr_i,
  input  wire logic [15:0]      param_wdata_i,
  // status register write (bit 7 completion, 5 access, 4 protect)
  input  wire logic             stat_wr_i,
  input  wire logic [7:0]       stat_wdata_i,
  // protection bits
  input  wire logic             low_region_protect_disable_i,
  input  wire logic             high_region_protect_disable_i,
  input  wire logic             program_memory_open_bit_i,
  input  wire logic             data_memory_open_bit_i,
  // chip mode and security (pins)
  input  wire logic [1:0]       chip_mode_i,
  input  wire logic             secured_i,
  // memory controller
  input  wire logic             mc_done_i,
  input  wire logic             mc_result_wr_i,
  input  wire logic [2:0]       mc_result_idx_i,
  input  wire logic [15:0]      mc_result_data_i,
  output logic                  mc_launch_o,
  output logic [7:0]            mc_cmd_o,
  output logic [16*PARAM_WORDS-1:0] mc_params_o,
  // status outputs
  output logic [DIV_W-1:0]      divider_value_field_o,
  output logic                  divider_loaded_bit_o,
  output logic [2:0]            parameter_index_field_o,
  output logic [15:0]           param_rdata_o,
  output logic                  command_complete_flag_o,
  output logic                  access_error_flag_o,
  output logic                  protection_violation_flag_o
);
  // =====================================================
  // pin synchronisers
  logic [1:0] mode_s1, mode_s2;                 // chip mode stages
  logic       sec_s1, sec_s2;                   // security stages
  // two flops before use
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode_s1 <= MODE_NS;
      mode_s2 <= MODE_NS;
      sec_s1  <= 1'b1;
      sec_s2  <= 1'b1;
    end else begin
      mode_s1 <= chip_mode_i;
      mode_s2 <= mode_s1;
      sec_s1  <= secured_i;
      sec_s2  <= sec_s1;
    end
  end

  // =====================================================
  // divider register
  logic [DIV_W-1:0] div_val;                    // divider value
  logic             div_ld;                     // loaded since reset
  logic             command_complete_flag;                       // completion flag

  // [RQ3] divider loaded flag
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      div_val <= DIV_RESET[DIV_W-1:0];
      div_ld  <= 1'b0;
    end else if (div_wr_i && command_complete_flag) begin
      div_val <= div_wdata_i;
      div_ld  <= 1'b1;
    end
  end

  // =====================================================
  // parameter index and array
  logic [2:0]  pidx;                            // selected word
  logic [15:0] parr [PARAM_WORDS];              // parameter words
  // [RQ8] index register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pidx <= IDX_RESET;
    end else if (idx_wr_i && command_complete_flag) begin
      pidx <= idx_wdata_i;
    end
  end

  // per-word storage
  genvar gi;
  generate
    for (gi = 0; gi < PARAM_WORDS; gi++) begin : g_word
      // [RQ6] busy blocks writes, [RQ10] results load
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          parr[gi] <= WORD_RESET;
        end else if (!command_complete_flag && mc_result_wr_i && mc_result_idx_i == 3'(gi)) begin
          parr[gi] <= mc_result_data_i;
        end else if (command_complete_flag && param_wr_i && pidx == 3'(gi)) begin
          parr[gi] <= param_wdata_i;
        end
      end
    end
  endgenerate

  // =====================================================
  // command decode
  logic [7:0] cmd;                              // code of word 0
  logic       known, pe_cmd, mode_ok, prot_ok;  // decode terms
  logic       spc;                              // special mode
  // [RQ23] code in high byte
  assign cmd = parr[0][CMD_HI_BIT -: 8];
  assign spc = (mode_s2 == MODE_SS) || (mode_s2 == MODE_ST);

  // classify the code
  always_comb begin
    known  = 1'b1;
    pe_cmd = 1'b0;
    unique case (cmd)
      // [RQ11] verify codes
      CMD_VFY_ALL, CMD_VFY_BLK, CMD_VFY_SECT: pe_cmd = 1'b0;
      // [RQ12] once field
      CMD_RD_ONCE:                            pe_cmd = 1'b0;
      CMD_PGM_ONCE:                           pe_cmd = 1'b1;
      // [RQ13] [RQ16] phrase and sector
      CMD_PGM_PH, CMD_ERS_SECT:               pe_cmd = 1'b1;
      // [RQ14] [RQ15] [RQ17] erases
      CMD_ERS_ALL, CMD_ERS_BLK, CMD_UNSEC:    pe_cmd = 1'b1;
      // [RQ17] [RQ18] key and margins
      CMD_KEY_VFY, CMD_USR_MRG, CMD_FLD_MRG:  pe_cmd = 1'b0;
      // [RQ19] data memory
      CMD_D_VFY:                              pe_cmd = 1'b0;
      CMD_D_PGM, CMD_D_ERS:                   pe_cmd = 1'b1;
      // [RQ24] unsupported code
      default:                                known  = 1'b0;
    endcase
  end

  // mode and security allowance
  always_comb begin
    mode_ok = 1'b0;
    unique case (cmd)
      // [RQ20] special modes only
      CMD_ERS_ALL, CMD_UNSEC: mode_ok = spc;
      CMD_FLD_MRG:            mode_ok = spc && !sec_s2;
      // [RQ22] normal single-chip only
      CMD_KEY_VFY:            mode_ok = (mode_s2 == MODE_NS);
      // [RQ21] verify all and verify block in all modes
      CMD_VFY_ALL, CMD_VFY_BLK: mode_ok = 1'b1;
      CMD_ERS_SECT:           mode_ok = sec_s2 ? (mode_s2 == MODE_NS) : (mode_s2 != MODE_NS);
      // [RQ21] secured keeps only normal single-chip
      default:                mode_ok = !sec_s2 || (mode_s2 == MODE_NS);
    endcase
  end

  // [RQ14] [RQ15] protection gating
  always_comb begin
    prot_ok = 1'b1;
    if (cmd == CMD_ERS_ALL) begin
      prot_ok = low_region_protect_disable_i && high_region_protect_disable_i &&
                program_memory_open_bit_i && data_memory_open_bit_i;
    end else if (cmd == CMD_ERS_BLK && parr[0][6:0] != 7'h00) begin
      prot_ok = low_region_protect_disable_i && high_region_protect_disable_i &&
                program_memory_open_bit_i;
    end
  end

  // =====================================================
  // status flags and launch
  logic launch_req, refuse, ok_go;              // launch terms
  fcl_state_t state;                            // sequencer state
  assign launch_req = stat_wr_i && stat_wdata_i[7] && command_complete_flag && !access_error_flag_o
                      && !protection_violation_flag_o;
  // [RQ4] program or erase needs divider
  assign refuse = !known || !mode_ok || (pe_cmd && !div_ld);
  assign ok_go  = launch_req && !refuse && prot_ok;

  // [RQ9] [RQ10] completion flag and sequencer
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= FCL_IDLE;
      command_complete_flag  <= 1'b1;
    end else begin
      unique case (state)
        FCL_IDLE: if (ok_go) begin
          command_complete_flag  <= 1'b0;
          state <= FCL_BUSY;
        end
        FCL_BUSY: if (mc_done_i) begin
          state <= FCL_DONE;
        end
        FCL_DONE: begin
          command_complete_flag  <= 1'b1;
          state <= FCL_IDLE;
        end
        // unused code, recover to idle with flag up
        default: begin
          command_complete_flag  <= 1'b1;
          state <= FCL_IDLE;
        end
      endcase
    end
  end

  // error flags, set wins over clear; [RQ25] refusal keeps command_complete_flag 1
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      access_error_flag_o         <= 1'b0;
      protection_violation_flag_o <= 1'b0;
    end else begin
      // [RQ24] [RQ25] refused launch
      if (launch_req && refuse) begin
        access_error_flag_o <= 1'b1;
      end else if (stat_wr_i && stat_wdata_i[5]) begin
        access_error_flag_o <= 1'b0;
      end
      if (launch_req && !refuse && !prot_ok) begin
        protection_violation_flag_o <= 1'b1;
      end else if (stat_wr_i && stat_wdata_i[4]) begin
        protection_violation_flag_o <= 1'b0;
      end
    end
  end

  // =====================================================
  // outputs from flops
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mc_launch_o             <= 1'b0;
      mc_cmd_o                <= 8'h00;
      mc_params_o             <= '0;
      param_rdata_o           <= WORD_RESET;
      divider_value_field_o   <= DIV_RESET[DIV_W-1:0];
      divider_loaded_bit_o    <= 1'b0;
      parameter_index_field_o <= IDX_RESET;
      command_complete_flag_o <= 1'b1;
    end else begin
      // [RQ9] hand array to controller
      mc_launch_o <= ok_go;
      if (ok_go) begin
        mc_cmd_o <= cmd;
        for (int k = 0; k < PARAM_WORDS; k++) begin
          mc_params_o[16*k +: 16] <= parr[k];
        end
      end
      param_rdata_o           <= (pidx < 3'(PARAM_WORDS)) ? parr[pidx] : WORD_RESET;
      divider_value_field_o   <= div_val;
      divider_loaded_bit_o    <= div_ld;
      parameter_index_field_o <= pidx;
      command_complete_flag_o <= command_complete_flag;
    end
  end

  // =====================================================
  // assertions
  // [RQ3] load shows two cycles after the write at output
  a_div_loaded_set: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ3]
    div_wr_i && command_complete_flag |-> ##2 divider_loaded_bit_o)
    else $error("divider loaded bit not set");
  // [RQ4] missing divider refuses program
  a_div_refuse: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ4]
    launch_req && pe_cmd && !div_ld |=> access_error_flag_o && command_complete_flag)
    else $error("launch without divider not refused");
  // [RQ6] busy array frozen against writes
  a_busy_ignore: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ6]
    !command_complete_flag && param_wr_i && !mc_result_wr_i |=> $stable(parr[pidx]))
    else $error("parameter write taken while busy");
  // [RQ9] launch clears flag and pulses
  a_launch_clear: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ9]
    ok_go |=> !command_complete_flag && mc_launch_o ##1 !mc_launch_o)
    else $error("launch did not clear completion");
  // [RQ10] done returns flag in two cycles
  a_done_set: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ10]
    state == FCL_BUSY && mc_done_i |-> ##2 command_complete_flag)
    else $error("completion flag not returned");
  // [RQ24] unknown code errors
  a_unknown_err: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ24]
    launch_req && !known |=> access_error_flag_o && !mc_launch_o)
    else $error("unknown code not refused");
  // [RQ22] key verify outside normal single-chip
  a_key_mode: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ22]
    launch_req && cmd == CMD_KEY_VFY && mode_s2 != MODE_NS |=> !mc_launch_o)
    else $error("key verify launched in wrong mode");
  // [RQ14] erase all needs open bits
  a_ers_all_prot: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ14]
    ok_go && cmd == CMD_ERS_ALL |-> data_memory_open_bit_i && program_memory_open_bit_i)
    else $error("erase all launched while protected");
  // [RQ25] refusal leaves command_complete_flag high
  a_refuse_idle: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ25]
    launch_req && refuse |=> command_complete_flag throughout ##1 1'b1)
    else $error("refused launch dropped completion");
  // [RQ8] unimplemented words read zero
  a_idx_unimpl: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ8]
    pidx >= 3'(PARAM_WORDS) |=> param_rdata_o == WORD_RESET)
    else $error("unimplemented word did not read zero");
  // [RQ20] special-only codes refused in normal modes
  a_special_only: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ20]
    launch_req && (cmd == CMD_ERS_ALL || cmd == CMD_UNSEC) && !spc |=> !mc_launch_o && access_error_flag_o)
    else $error("special-only code launched in normal mode");
  // [RQ21] secured expanded mode keeps only verify all and verify block
  a_secured_limit: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ21]
    launch_req && sec_s2 && mode_s2 == MODE_NX && cmd != CMD_VFY_ALL && cmd != CMD_VFY_BLK |=> !mc_launch_o)
    else $error("secured expanded mode launched a restricted code");
endmodule // fcl_top

// file: tb/fcl_top_test.sv
`timescale 1ns/100ps
module fcl_top_test import fcl_pkg::*;;
  // =====================================================
  // stimulus and observation signals
  logic        clock_i, rst_i;                          // clock and sync reset
  logic        div_wr_i, idx_wr_i, param_wr_i, stat_wr_i; // write strobes
  logic [5:0]  div_wdata_i;                             // divider data
  logic [2:0]  idx_wdata_i;                             // index data
  logic [15:0] param_wdata_i;                           // array word data
  logic [7:0]  stat_wdata_i;                            // status write data
  logic        lo_dis, hi_dis, p_open, d_open;          // protection levels
  logic [1:0]  mode;                                    // chip mode pins
  logic        sec;                                     // security pin
  logic        mc_done, mc_rwr;                         // controller side
  logic [2:0]  mc_ridx;                                 // result index
  logic [15:0] mc_rdata;                                // result word
  logic        launch, divld, cc, acc, pv;              // design flags
  logic [7:0]  cmd;                                     // launched code
  logic [95:0] params;                                  // handed-over array
  logic [5:0]  divv;                                    // divider readback
  logic [2:0]  idx_o;                                   // index readback
  logic [15:0] rdata;                                   // word readback
  int          err_total, num_checks;                   // tallies
  logic [7:0]  codes [18] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a,
                              8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12, 8'h05, 8'h13};
  // =====================================================
  // device under test
  fcl_top #(.DIV_W(6)) u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .div_wr_i(div_wr_i), .div_wdata_i(div_wdata_i),
    .idx_wr_i(idx_wr_i), .idx_wdata_i(idx_wdata_i), .param_wr_i(param_wr_i),
    .param_wdata_i(param_wdata_i), .stat_wr_i(stat_wr_i), .stat_wdata_i(stat_wdata_i),
    .low_region_protect_disable_i(lo_dis), .high_region_protect_disable_i(hi_dis),
    .program_memory_open_bit_i(p_open), .data_memory_open_bit_i(d_open),
    .chip_mode_i(mode), .secured_i(sec), .mc_done_i(mc_done), .mc_result_wr_i(mc_rwr),
    .mc_result_idx_i(mc_ridx), .mc_result_data_i(mc_rdata), .mc_launch_o(launch),
    .mc_cmd_o(cmd), .mc_params_o(params), .divider_value_field_o(divv),
    .divider_loaded_bit_o(divld), .parameter_index_field_o(idx_o), .param_rdata_o(rdata),
    .command_complete_flag_o(cc), .access_error_flag_o(acc), .protection_violation_flag_o(pv));
  // =====================================================
  // clock generation
  // bus clock well above 1 MHz
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // =====================================================
  // helpers
  // accepted modes per code, bit = secured*4 + mode
  function automatic logic [7:0] allow(input logic [7:0] c);
    case (c)
      8'h01, 8'h02: allow = 8'hff;
      8'h08, 8'h0b: allow = 8'hcc;
      8'h0a:        allow = 8'h1e;
      8'h0c:        allow = 8'h11;
      8'h0e:        allow = 8'h0c;
      8'h05, 8'h13: allow = 8'h00;
      default:      allow = 8'h1f;
    endcase
  endfunction
  // compare and tally
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one-cycle write strobe: 0 divider, 1 index, 2 array word, 3 status
  task automatic pulse(input int which, input logic [15:0] d);
    @(posedge clock_i);
    case (which)
      0: begin div_wr_i <= 1'b1; div_wdata_i <= d[5:0]; end
      1: begin idx_wr_i <= 1'b1; idx_wdata_i <= d[2:0]; end
      2: begin param_wr_i <= 1'b1; param_wdata_i <= d; end
      default: begin stat_wr_i <= 1'b1; stat_wdata_i <= d[7:0]; end
    endcase
    @(posedge clock_i);
    {div_wr_i, idx_wr_i, param_wr_i, stat_wr_i} <= 4'h0;
  endtask
  // controller finishes, completion must return in a bounded time
  task automatic finish_cmd;
    int n;
    n = 0;
    @(posedge clock_i);
    mc_done <= 1'b1;
    @(posedge clock_i);
    mc_done <= 1'b0;
    while (cc !== 1'b1 && n < 20) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n == 20) begin
      err_total++;
      final_report();
    end
  endtask
  // mode pins pass a two-flop sync, so allow settling edges
  task automatic set_mode(input logic [1:0] m, input logic s);
    @(posedge clock_i);
    mode <= m;
    sec  <= s;
    repeat (4) @(posedge clock_i);
  endtask
  // launch a code; e: 0 accepted, 1 access error, 2 protection error
  task automatic run(input logic [7:0] c, input int e);
    pulse(1, 16'h0000);
    pulse(2, {c, 8'h00});
    pulse(3, 16'h0080);
    #1;
    chk(launch, e == 0);
    if (e == 0) chk(cmd, c);
    @(posedge clock_i);
    #1;
    chk(cc, e != 0);
    chk({acc, pv}, {e == 1, e == 2});
    if (e == 0) begin
      finish_cmd();
    end else begin
      pulse(3, 16'h0030);
      #1;
      chk({acc, pv}, 2'b00);
    end
  endtask
  // =====================================================
  // main sequence
  initial begin
    {div_wr_i, idx_wr_i, param_wr_i, stat_wr_i, mc_done, mc_rwr, sec} = '0;
    {div_wdata_i, idx_wdata_i, param_wdata_i, stat_wdata_i, mode, mc_ridx, mc_rdata} = '0;
    {lo_dis, hi_dis, p_open, d_open} = 4'hf;
    err_total  = 0;
    num_checks = 0;
    rst_i = 1'b1;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    set_mode(MODE_NS, 1'b0);
    #1;
    chk({cc, acc, pv, divld}, 4'h8);
    // program refused before divider load, verify still runs
    run(CMD_PGM_PH, 1);
    run(CMD_VFY_ALL, 0);
    pulse(0, 16'h0013);
    // status outputs mirror the registers one edge later
    @(posedge clock_i);
    #1;
    chk({divld, divv}, 7'h53);
    // indexed array access and unimplemented words
    pulse(1, 16'h0005);
    pulse(2, 16'h5a5a);
    @(posedge clock_i);
    #1;
    chk({idx_o, rdata}, 19'h55a5a);
    pulse(1, 16'h0006);
    pulse(2, 16'haaaa);
    #1;
    chk(rdata, 16'h0000);
    // writing zero to the completion bit does nothing
    pulse(3, 16'h0000);
    @(posedge clock_i);
    #1;
    chk({launch, cc}, 2'b01);
    // erase all with data memory closed
    d_open <= 1'b0;
    set_mode(MODE_SS, 1'b0);
    run(CMD_ERS_ALL, 2);
    d_open <= 1'b1;
    // every code in every mode and security state
    for (int k = 0; k < 8; k++) begin
      set_mode(k[1:0], k[2]);
      for (int j = 0; j < 18; j++) begin
        run(codes[j], ((allow(codes[j]) >> k) & 8'h01) != 8'h00 ? 0 : 1);
      end
    end
    // busy: launches and array writes ignored, results readable
    pulse(1, 16'h0000);
    pulse(2, 16'h0100);
    pulse(3, 16'h0080);
    #1;
    chk(params[95:80], 16'h5a5a);
    @(posedge clock_i);
    mc_rwr   <= 1'b1;
    mc_rdata <= 16'h1234;
    @(posedge clock_i);
    mc_rwr <= 1'b0;
    pulse(2, 16'hbeef);
    pulse(3, 16'h0080);
    #1;
    chk({launch, cc}, 2'b00);
    finish_cmd();
    chk(rdata, 16'h1234);
    final_report();
  end
endmodule // fcl_top_test
